// ---- common/dps_consts.svh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH

// ****************************************************************
// Register offsets on the control port.
// ****************************************************************
`define DPS_ADDR_PWR1      8'h01
`define DPS_ADDR_LINE3     8'h15
`define DPS_ADDR_LINE1     8'h16
`define DPS_ADDR_LINE2     8'h17
`define DPS_ADDR_AP2       8'h39
`define DPS_ADDR_CP        8'h4C
`define DPS_ADDR_LAUNCH    8'h49
`define DPS_ADDR_SERVO     8'h54
`define DPS_ADDR_HP        8'h60
`define DPS_ADDR_DUMMY     8'hFF

// ****************************************************************
// Launch commands and program entry points.
// ****************************************************************
`define DPS_CMD_STARTUP    16'h0100
`define DPS_CMD_SHUTDOWN   16'h0110
`define DPS_IDX_STARTUP    5'h00
`define DPS_IDX_SHUTDOWN   5'h10

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define DPS_CLAMP_BIT      0
`define DPS_MIDBUF_BIT     3
`define DPS_ZERO_RESET     16'h0000
`define DPS_LINE_RESET     16'h0001
`define DPS_AP2_RESET      16'h0008

// ****************************************************************
// Step timing: one unit is 62.5 us, a step lasts 2^code + 8 units.
// ****************************************************************
`define DPS_STEP_UNIT_NS   62500
`define DPS_CLK_PERIOD_NS  4
`define DPS_UNIT_CYCLES    (`DPS_STEP_UNIT_NS / `DPS_CLK_PERIOD_NS)
`define DPS_UNITS_BASE     16'h0008
`define DPS_NUM_REGS       8

`endif

// ---- common/dps_pkg.sv ----
// Types shared by the default power sequencer and its step memory.
`default_nettype none
package dps_pkg;

    // One sequencer step as held in the step memory.
    typedef struct packed {
        logic [7:0] addr;              // Target register.
        logic [2:0] step_field_width;  // Width minus one.
        logic [3:0] step_field_lsb;    // Lowest bit written.
        logic [7:0] data;              // Value, low bits used.
        logic [3:0] step_delay_code;   // Step length code.
        logic       step_last_flag;    // Stop after this step.
    } dps_step_s;

    // Sequencer states.
    typedef enum logic [1:0] {
        DPS_IDLE  = 2'b00,
        DPS_FETCH = 2'b01,
        DPS_EXEC  = 2'b10,
        DPS_WAIT  = 2'b11
    } dps_state_e;

endpackage : dps_pkg
`default_nettype wire

// ---- rtl/dps_step_rom.sv ----
// Step memory holding the built-in start-up and shut-down programs.
`timescale 1ns/1ps
`default_nettype none
`include "dps_consts.svh"

module dps_step_rom (
    input  wire logic             clock_in,  // System clock.
    input  wire logic             reset_in,  // Asynchronous reset.
    input  wire logic [4:0]       index_in,  // Step index.
    output dps_pkg::dps_step_s    step_out   // Registered step.
);
    import dps_pkg::*;

    dps_step_s entry;

    // ****************************************************************
    // Program contents.
    // ****************************************************************
    // Unused indices hold a final dummy step, so a stray launch stops.
    always_comb begin
        entry = '{`DPS_ADDR_DUMMY, 3'h0, 4'h0, 8'h00, 4'h0, 1'b1};
        case (index_in)
            5'h00: entry = '{`DPS_ADDR_CP, 3'h0, 4'hF, 8'h01,
                             4'h6, 1'b0};
            5'h01: entry = '{`DPS_ADDR_PWR1, 3'h2, 4'h7, 8'h07,
                             4'h0, 1'b0};
            5'h02: entry = '{`DPS_ADDR_HP, 3'h4, 4'h1, 8'h11,
                             4'h0, 1'b0};
            5'h03: entry = '{`DPS_ADDR_SERVO, 3'h6, 4'h0, 8'h33,
                             4'h9, 1'b0};
            5'h04: entry = '{`DPS_ADDR_DUMMY, 3'h0, 4'h0, 8'h00,
                             4'h5, 1'b0};
            5'h05,
            5'h06: entry = '{`DPS_ADDR_DUMMY, 3'h0, 4'h0, 8'h00,
                             4'h0, 1'b0};
            5'h07: entry = '{`DPS_ADDR_HP, 3'h5, 4'h2, 8'h3B,
                             4'h0, 1'b1};
            5'h10: entry = '{`DPS_ADDR_HP, 3'h6, 4'h1, 8'h00,
                             4'h0, 1'b0};
            5'h11: entry = '{`DPS_ADDR_SERVO, 3'h1, 4'h0, 8'h00,
                             4'h0, 1'b0};
            5'h12: entry = '{`DPS_ADDR_PWR1, 3'h1, 4'h8, 8'h00,
                             4'h0, 1'b0};
            5'h13: entry = '{`DPS_ADDR_CP, 3'h0, 4'hF, 8'h00,
                             4'h0, 1'b0};
            5'h14: entry = '{`DPS_ADDR_PWR1, 3'h1, 4'hC, 8'h00,
                             4'h0, 1'b1};
            default: entry = '{`DPS_ADDR_DUMMY, 3'h0, 4'h0, 8'h00,
                               4'h0, 1'b1};
        endcase
    end

    // Read data leave through a register, one cycle after the index.
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            step_out <= '0;
        end else begin
            step_out <= entry;
        end
    end

endmodule : dps_step_rom
`default_nettype wire

// ---- rtl/dps_sequencer.sv ----
// Default power sequencer with its target registers and input clamps.
`timescale 1ns/1ps
`default_nettype none
`include "dps_consts.svh"

module dps_sequencer #(
    parameter int UNIT_CYCLES = `DPS_UNIT_CYCLES  // Cycles per 62.5 us.
) (
    input  wire logic        clock_in,             // System clock.
    input  wire logic        reset_in,             // Asynchronous reset.
    input  wire logic        reg_wr_in,            // Register write strobe.
    input  wire logic        reg_rd_in,            // Register read strobe.
    input  wire logic [7:0]  reg_addr_in,          // Register address.
    input  wire logic [15:0] reg_wdata_in,         // Write data.
    input  wire logic [2:0]  line_stage_on_in,     // Input stages 1..3 on.
    output logic      [15:0] reg_rdata_out,        // Read data.
    output logic             busy_out,             // Program running.
    output logic      [4:0]  step_index_out,       // Index being fetched.
    output logic      [15:0] power_mgmt_out,       // Register 01h.
    output logic      [15:0] charge_pump_out,      // Register 4Ch.
    output logic      [15:0] offset_servo_out,     // Register 54h.
    output logic      [15:0] hp_analog_out,        // Register 60h.
    output logic      [2:0]  line_clamp_on_out,    // Pins tied to mid-rail.
    output logic             midrail_buffer_on_out // Mid-rail buffer on.
);
    import dps_pkg::*;

    // ****************************************************************
    // Helper functions.
    // ****************************************************************
    // Maps an address to a register slot; 8 means not held here.
    function automatic logic [3:0] slot_of(input logic [7:0] addr);
        case (addr)
            `DPS_ADDR_PWR1:  slot_of = 4'h0;
            `DPS_ADDR_CP:    slot_of = 4'h1;
            `DPS_ADDR_SERVO: slot_of = 4'h2;
            `DPS_ADDR_HP:    slot_of = 4'h3;
            `DPS_ADDR_LINE3: slot_of = 4'h4;
            `DPS_ADDR_LINE1: slot_of = 4'h5;
            `DPS_ADDR_LINE2: slot_of = 4'h6;
            `DPS_ADDR_AP2:   slot_of = 4'h7;
            default:         slot_of = 4'h8;
        endcase
    endfunction : slot_of

    // Reset value of a register slot.
    function automatic logic [15:0] reset_of(input int slot);
        case (slot)
            4, 5, 6: reset_of = `DPS_LINE_RESET;
            7:       reset_of = `DPS_AP2_RESET;
            default: reset_of = `DPS_ZERO_RESET;
        endcase
    endfunction : reset_of

    // Merges a step field into a register word.
    function automatic logic [15:0] merge_field(input logic [15:0] old,
                                                input dps_step_s st);
        logic [7:0]  low;
        logic [15:0] mask;
        logic [15:0] value;
        // Width plus one needs four bits, or an 8-bit field wraps to none.
        low   = 8'((9'h001 << ({1'b0, st.step_field_width} + 4'h1)) - 9'h001);
        mask  = 16'({8'h00, low} << st.step_field_lsb);
        value = 16'({8'h00, st.data & low} << st.step_field_lsb);
        merge_field = (old & ~mask) | value;
    endfunction : merge_field

    // ****************************************************************
    // Sequencer state.
    // ****************************************************************
    dps_state_e  state;
    dps_step_s   rom_q;
    dps_step_s   cur_step;
    logic [4:0]  index;
    logic [15:0] unit_cnt;
    logic [15:0] units_left;
    logic [15:0] launch_value;
    logic [15:0] regs [`DPS_NUM_REGS];
    logic        launch_ok;
    logic        unit_tick;
    logic        step_done;
    logic        seq_wr;
    logic [3:0]  seq_slot;
    logic [3:0]  host_slot;

    // A launch is only honoured from idle, and only the two commands.
    assign launch_ok = reg_wr_in && (reg_addr_in == `DPS_ADDR_LAUNCH)
                       && (state == DPS_IDLE)
                       && ((reg_wdata_in == `DPS_CMD_STARTUP)
                           || (reg_wdata_in == `DPS_CMD_SHUTDOWN));
    assign unit_tick = (unit_cnt == 16'(UNIT_CYCLES - 1));
    assign step_done = (state == DPS_WAIT) && unit_tick
                       && (units_left == 16'h0001);
    assign seq_wr    = (state == DPS_EXEC);
    assign seq_slot  = slot_of(rom_q.addr);
    assign host_slot = slot_of(reg_addr_in);

    dps_step_rom u_rom (
        .clock_in (clock_in),
        .reset_in (reset_in),
        .index_in (index),
        .step_out (rom_q)
    );

    // Main sequence control; the first step has its own fetch cycle, later fetches sit inside the prior step.
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state    <= DPS_IDLE;
            index    <= 5'h00;
            cur_step <= '0;
        end else begin
            case (state)
                DPS_IDLE: begin
                    if (launch_ok) begin
                        if (reg_wdata_in == `DPS_CMD_STARTUP) begin
                            index <= `DPS_IDX_STARTUP;
                        end else begin
                            index <= `DPS_IDX_SHUTDOWN;
                        end
                        state <= DPS_FETCH;
                    end
                end
                DPS_FETCH: begin
                    state <= DPS_EXEC;
                end
                DPS_EXEC: begin
                    cur_step <= rom_q;
                    index    <= index + 5'h01;
                    state    <= DPS_WAIT;
                end
                DPS_WAIT: begin
                    if (step_done) begin
                        if (cur_step.step_last_flag) begin
                            state <= DPS_IDLE;
                        end else begin
                            state <= DPS_EXEC;
                        end
                    end
                end
                default: begin
                    state <= DPS_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Step timer.
    // ****************************************************************
    // The write cycle counts as the first cycle of the step, so the
    // unit counter starts at one; this needs UNIT_CYCLES of two or more.
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            unit_cnt   <= 16'h0000;
            units_left <= 16'h0000;
        end else if (state == DPS_EXEC) begin
            unit_cnt   <= 16'h0001;
            units_left <= 16'(17'h00001 << rom_q.step_delay_code)
                          + `DPS_UNITS_BASE;
        end else if (state == DPS_WAIT) begin
            if (unit_tick) begin
                unit_cnt   <= 16'h0000;
                units_left <= units_left - 16'h0001;
            end else begin
                unit_cnt <= unit_cnt + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // Register file.
    // ****************************************************************
    // The step write lands after the host write of the same cycle, so
    // the program wins a collision; writes to FFh fall on no slot.
    generate
        for (genvar g = 0; g < `DPS_NUM_REGS; g++) begin : g_reg
            logic [15:0] after_host;
            assign after_host = (reg_wr_in && host_slot == 4'(g))
                                ? reg_wdata_in : regs[g];
            always_ff @(posedge clock_in or posedge reset_in) begin
                if (reset_in) begin
                    regs[g] <= reset_of(g);
                end else if (seq_wr && seq_slot == 4'(g)) begin
                    regs[g] <= merge_field(after_host, rom_q);
                end else begin
                    regs[g] <= after_host;
                end
            end
        end
    endgenerate

    // Last accepted launch command, kept for read-back.
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            launch_value <= 16'h0000;
        end else if (launch_ok) begin
            launch_value <= reg_wdata_in;
        end
    end

    // Read data appear one cycle after the strobe; unmapped reads zero.
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            if (reg_addr_in == `DPS_ADDR_LAUNCH) begin
                reg_rdata_out <= launch_value;
            end else if (host_slot < 4'h8) begin
                reg_rdata_out <= regs[host_slot[2:0]];
            end else begin
                reg_rdata_out <= 16'h0000;
            end
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    // Copies of the register words; one cycle later than the registers
    // themselves, which is harmless against analogue settling times.
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            power_mgmt_out        <= `DPS_ZERO_RESET;
            charge_pump_out       <= `DPS_ZERO_RESET;
            offset_servo_out      <= `DPS_ZERO_RESET;
            hp_analog_out         <= `DPS_ZERO_RESET;
            midrail_buffer_on_out <= 1'b1;
            busy_out              <= 1'b0;
            step_index_out        <= 5'h00;
        end else begin
            power_mgmt_out        <= regs[0];
            charge_pump_out       <= regs[1];
            offset_servo_out      <= regs[2];
            hp_analog_out         <= regs[3];
            midrail_buffer_on_out <= regs[7][`DPS_MIDBUF_BIT];
            busy_out              <= (state != DPS_IDLE) || launch_ok;
            step_index_out        <= index;
        end
    end

    // A pin pair is clamped only while its input stage is off.
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            line_clamp_on_out <= 3'h0;
        end else begin
            line_clamp_on_out[0] <= regs[5][`DPS_CLAMP_BIT]
                                    && !line_stage_on_in[0];
            line_clamp_on_out[1] <= regs[6][`DPS_CLAMP_BIT]
                                    && !line_stage_on_in[1];
            line_clamp_on_out[2] <= regs[4][`DPS_CLAMP_BIT]
                                    && !line_stage_on_in[2];
        end
    end

endmodule : dps_sequencer
`default_nettype wire

// ---- verification/dps_sequencer_properties.sv ----
// Concurrent checks on the default power sequencer ports.
`timescale 1ns/1ps
`default_nettype none

module dps_sequencer_properties #(
    parameter int UNIT_CYCLES = 15625  // Cycles per step unit.
) (
    input wire logic        clock_in,              // Clock.
    input wire logic        reset_in,              // Reset.
    input wire logic        reg_wr_in,             // Write strobe.
    input wire logic        reg_rd_in,             // Read strobe.
    input wire logic [7:0]  reg_addr_in,           // Address.
    input wire logic [15:0] reg_wdata_in,          // Write data.
    input wire logic [2:0]  line_stage_on_in,      // Stages on.
    input wire logic [15:0] reg_rdata_out,         // Read data.
    input wire logic        busy_out,              // Running.
    input wire logic [4:0]  step_index_out,        // Index.
    input wire logic [15:0] power_mgmt_out,        // Register 01h.
    input wire logic [15:0] charge_pump_out,       // Register 4Ch.
    input wire logic [15:0] offset_servo_out,      // Register 54h.
    input wire logic [15:0] hp_analog_out,         // Register 60h.
    input wire logic [2:0]  line_clamp_on_out,     // Clamps.
    input wire logic        midrail_buffer_on_out  // Buffer.
);
    localparam int STEP9   = 9 * UNIT_CYCLES;
    localparam int TAIL_LO = STEP9 - 4;
    localparam int TAIL_HI = STEP9 + 4;
    localparam int STEP0_M1 = 72 * UNIT_CYCLES - 1;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    // The last step runs its full length before busy drops.
    sequence finish_s;
        busy_out ##[TAIL_LO:TAIL_HI] $fell(busy_out);
    endsequence

    // Step zero holds the next power write back for its full 72 units.
    sequence step_one_s;
        ##STEP0_M1 $stable(power_mgmt_out) ##1 $changed(power_mgmt_out);
    endsequence

    busy_start_a:
        assert property (!busy_out && reg_wr_in && reg_addr_in == 8'h49 &&
            (reg_wdata_in == 16'h0100 || reg_wdata_in == 16'h0110)
            |-> ##[1:2] busy_out) else $error("Launch did not start.");
    busy_min_a:
        assert property ($rose(busy_out) |-> busy_out[*8])
        else $error("Program ended too soon.");
    step_zero_a:
        assert property ($rose(charge_pump_out[15]) && busy_out
            |-> step_one_s) else $error("Step zero length wrong.");
    last_step_a:
        assert property ($rose(hp_analog_out[7]) && busy_out |-> finish_s)
        else $error("Start-up did not stop after its last step.");
    shut_end_a:
        assert property ($fell(charge_pump_out[15]) && busy_out
            |-> ##STEP9 power_mgmt_out[13:12] == 2'b00)
        else $error("Final shut-down step late or missing.");
    quiet_idle_a:
        assert property (!busy_out && !$past(busy_out) && !$past(reg_wr_in)
            && !$past(reg_wr_in, 2) |-> $stable(hp_analog_out)
            && $stable(power_mgmt_out) && $stable(charge_pump_out))
        else $error("Register moved while idle.");
    clamp_stage_a:
        assert property ((line_clamp_on_out & $past(line_stage_on_in)) == 0)
        else $error("Clamp on while its input stage is on.");
    midrail_wr_a:
        assert property (reg_wr_in && reg_addr_in == 8'h39 |-> ##2
            midrail_buffer_on_out == |($past(reg_wdata_in, 2) & 16'h0008))
        else $error("Mid-rail buffer does not follow its bit.");
endmodule : dps_sequencer_properties

bind dps_sequencer dps_sequencer_properties #(
    .UNIT_CYCLES(UNIT_CYCLES)
) i_dps_sequencer_properties (
    .clock_in(clock_in), .reset_in(reset_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .line_stage_on_in(line_stage_on_in),
    .reg_rdata_out(reg_rdata_out), .busy_out(busy_out),
    .step_index_out(step_index_out), .power_mgmt_out(power_mgmt_out),
    .charge_pump_out(charge_pump_out), .offset_servo_out(offset_servo_out),
    .hp_analog_out(hp_analog_out), .line_clamp_on_out(line_clamp_on_out),
    .midrail_buffer_on_out(midrail_buffer_on_out));
`default_nettype wire

// ---- verification/dps_host_model.sv ----
// Host model that drives the sequencer register port.
`timescale 1ns/1ps
`default_nettype none

module dps_host_model (
    input  wire logic        clock_in,      // System clock.
    output logic             reg_wr_out,    // Write strobe.
    output logic             reg_rd_out,    // Read strobe.
    output logic      [7:0]  reg_addr_out,  // Address.
    output logic      [15:0] reg_wdata_out  // Write data.
);
    // Quiet port at time zero.
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 8'h00;
        reg_wdata_out = 16'h0000;
    end

    // One strobe cycle; any data is driven, so launches can carry codes other than the two documented ones.
    // Released lines show inverted values so stale data never looks valid.
    task automatic strobe(input logic wr, input logic [7:0] a,
                          input logic [15:0] d);
        @(posedge clock_in);
        #1;
        reg_wr_out = wr;
        reg_rd_out = !wr;
        reg_addr_out = a;
        reg_wdata_out = d;
        @(posedge clock_in);
        #1;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask : strobe
endmodule : dps_host_model
`default_nettype wire

// ---- verification/dps_sequencer_test.sv ----
// Self-checking bench for the default power sequencer.
`timescale 1ns/1ps
`default_nettype none

module dps_sequencer_test;
    import dps_pkg::*;
    localparam int UNIT = 4;  // Short unit keeps the start-up run brief.
    logic        clock_in, reset_in = 1'b1, reg_wr, reg_rd, busy, midbuf;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, rdata, pm, cp, os, hp, d;
    logic [2:0]  stage = 3'b000, clamp;
    logic [4:0]  idx;
    logic [63:0] snap;
    logic [7:0]  rd_list[10] = '{8'h01, 8'h15, 8'h16, 8'h17, 8'h39,
                                 8'h4C, 8'h49, 8'h54, 8'h60, 8'h02};
    logic [7:0]  wr_list[9] = '{8'h15, 8'h16, 8'h17, 8'h39, 8'h02,
                                8'h01, 8'h4C, 8'h54, 8'h60};
    int          num_errors = 0, checked = 0, cyc = 0, t_last = 0;
    int          model[256], gaps[$], exp_gaps[$];
    // Rows: address, lsb, width, data, delay code, last flag.
    int          steps[13][6] = '{
        '{8'h4C, 15, 1, 8'h01, 6, 0}, '{8'h01, 7, 3, 8'h07, 0, 0},
        '{8'h60, 1, 5, 8'h11, 0, 0}, '{8'h54, 0, 7, 8'h33, 9, 0},
        '{8'hFF, 0, 1, 8'h00, 5, 0}, '{8'hFF, 0, 1, 8'h00, 0, 0},
        '{8'hFF, 0, 1, 8'h00, 0, 0}, '{8'h60, 2, 6, 8'h3B, 0, 1},
        '{8'h60, 1, 7, 8'h00, 0, 0}, '{8'h54, 0, 2, 8'h00, 0, 0},
        '{8'h01, 8, 2, 8'h00, 0, 0}, '{8'h4C, 15, 1, 8'h00, 0, 0},
        '{8'h01, 12, 2, 8'h00, 0, 1}};

    dps_sequencer #(.UNIT_CYCLES(UNIT)) i_dps_sequencer (
        .clock_in(clock_in), .reset_in(reset_in), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .line_stage_on_in(stage), .reg_rdata_out(rdata), .busy_out(busy),
        .step_index_out(idx), .power_mgmt_out(pm), .charge_pump_out(cp),
        .offset_servo_out(os), .hp_analog_out(hp), .line_clamp_on_out(clamp),
        .midrail_buffer_on_out(midbuf));
    dps_host_model i_dps_host_model (
        .clock_in(clock_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
        .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata));

    // Free-running 250 MHz clock.
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    // Spacing between register changes while busy gives the time from each writing step to the next.
    always @(posedge clock_in) begin
        cyc++;
        if (busy === 1'b1 && {pm, cp, os, hp} !== snap) begin
            if (t_last > 0) gaps.push_back(cyc - t_last);
            t_last = cyc;
        end
        snap = {pm, cp, os, hp};
        if (cyc == 10000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        if (num_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize

    // Reads every mapped place plus one unmapped address that must read 0.
    task automatic sweep();
        foreach (rd_list[i]) begin
            i_dps_host_model.strobe(1'b0, rd_list[i], 16'h0000);
            check("readback", rdata, model[rd_list[i]][15:0]);
        end
    endtask : sweep

    // Reference model: merges each field, sums step units between writes.
    task automatic run_prog(input logic [15:0] cmd, other, input int row);
        int m;
        int u;
        int r0;
        u = -1;
        r0 = row;
        exp_gaps.delete();
        do begin
            if (steps[row][0] != 8'hFF && u >= 0) exp_gaps.push_back(u * UNIT);
            if (steps[row][0] != 8'hFF) u = 0;
            m = ((1 << steps[row][2]) - 1) << steps[row][1];
            model[steps[row][0]] = (model[steps[row][0]] & ~m) |
                ((steps[row][3] << steps[row][1]) & m);
            u += (1 << steps[row][4]) + 8;
            row++;
        end while (steps[row - 1][5] == 0);
        gaps.delete();
        t_last = 0;
        model[8'h49] = cmd;
        i_dps_host_model.strobe(1'b1, 8'h49, cmd);
        wait (busy === 1'b1);
        i_dps_host_model.strobe(1'b1, 8'h49, other);
        wait (busy === 1'b0);
        check("power", pm, model[8'h01][15:0]);
        check("pump", cp, model[8'h4C][15:0]);
        check("servo", os, model[8'h54][15:0]);
        check("hp", hp, model[8'h60][15:0]);
        check("index", idx, (cmd == 16'h0110 ? 16 : 0) + row - r0);
        check("steps", gaps.size(), exp_gaps.size());
        foreach (exp_gaps[i]) check("gap", gaps[i], exp_gaps[i]);
    endtask : run_prog

    // Reset, clamps, refused launch, then both programs back to back.
    initial begin
        void'($urandom(32'h85C6));
        foreach (model[a]) model[a] = 0;
        {model[8'h15], model[8'h16], model[8'h17], model[8'h39]} = {32'h1,
            32'h1, 32'h1, 32'h8};
        repeat (5) @(posedge clock_in);
        #1 reset_in = 1'b0;
        repeat (2) @(posedge clock_in);
        #1 check("clamp", clamp, 3'b111);
        check("midbuf", midbuf, 1'b1);
        sweep();
        repeat (3) begin
            foreach (wr_list[i]) begin
                d = 16'($urandom());
                if (i == 5) d = (d & 16'hFC7F) | 16'h3000;
                if (i > 5) d = d & 16'({16'h7FFF, 16'hFF80, 16'hFF01}
                                       >> (16 * (8 - i)));
                i_dps_host_model.strobe(1'b1, wr_list[i], d);
                if (i != 4) model[wr_list[i]] = d;
            end
            stage = 3'($urandom());
            repeat (2) @(posedge clock_in);
            #1 check("clamp", clamp, {model[8'h15][0], model[8'h17][0],
                model[8'h16][0]} & ~stage);
            check("midbuf", midbuf, model[8'h39][3]);
            sweep();
        end
        i_dps_host_model.strobe(1'b1, 8'h49, 16'h0101);
        repeat (3) @(posedge clock_in);
        #1 check("busy", busy, 1'b0);
        run_prog(16'h0100, 16'h0110, 0);
        run_prog(16'h0110, 16'h0100, 8);
        sweep();
        summarize();
    end
endmodule : dps_sequencer_test
`default_nettype wire
